/* cc_clock_ctrl.sv */
// The register offsets and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module cc_clock_ctrl (
	input wire logic clk,
	input wire logic nrst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Source clock levels and stable flags
	input wire cc_pkg::cc_src_t srcLevel,
	input wire cc_pkg::cc_src_t srcStable,
	// Core side
	input wire logic waitForInterruptInstr,
	input wire logic wakeIrq,
	input wire logic coreClk,
	input wire logic tickClockSourceSelect,
	// Oscillator controls
	output cc_pkg::cc_src_t srcEnable,
	output logic pllRefSelect,
	// Clock outputs
	output logic sysClk,
	output logic tickClk,
	output logic [cc_pkg::NUM_PERIPH-1:0] periphClk,
	output logic clockOutPin,
	output logic powerdownActive
);

	// ****************************************************************
	// Registers and state
	// ****************************************************************
	logic [4:0] pwrCtrl;
	logic [cc_pkg::NUM_PERIPH-1:0] clkEnable;
	logic pllCtrl;
	logic [5:0] clockSelect0;
	logic [7:0] clockSelect1;
	logic [7:0] clockSelect2;
	logic [4:0] clockDividerOutCtrl;
	cc_pkg::cc_pstate_t pstate;
	cc_pkg::cc_pstate_t next_pstate;
	logic [cc_pkg::NUM_MUX-1:0][2:0] reqSel;
	logic [cc_pkg::NUM_MUX-1:0][2:0] curSel;
	logic [cc_pkg::NUM_MUX-1:0] gateOn;
	logic [cc_pkg::NUM_MUX-1:0] allow;
	logic [cc_pkg::NUM_MUX-1:0] muxOut;
	logic [cc_pkg::DIV_STAGES-1:0] divCount;
	logic divRunning;
	logic divInPrev;
	logic wrEn;
	logic setupPhase;
	logic sysSrcStable;
	logic [31:0] next_rdata;
	logic next_err;

	// Level of one source picked by a select code; unused codes fall to the internal oscillator
	function automatic logic pickSrc(input logic [2:0] sel, input cc_pkg::cc_src_t lv);
		logic r;
		r = lv.hirc;
		case (sel)
			cc_pkg::SRC_HXT: r = lv.hxt;
			cc_pkg::SRC_LXT: r = lv.lxt;
			cc_pkg::SRC_PLL: r = lv.pll;
			cc_pkg::SRC_LIRC: r = lv.lirc;
			default: r = lv.hirc;
		endcase
		return r;
	endfunction : pickSrc

	// Low-frequency sources survive power-down
	function automatic logic isLowFreq(input logic [2:0] sel);
		return (sel == cc_pkg::SRC_LXT) || (sel == cc_pkg::SRC_LIRC);
	endfunction : isLowFreq

	// ****************************************************************
	// APB slave
	// ****************************************************************
	// Setup is a selected, not yet enabled cycle with no answer pending;
	// only the access cycle that follows it may land a write
	assign setupPhase = psel && !penable && !pready;
	assign wrEn = psel && penable && pready && pwrite;

	// Read data and decode prepared in the setup cycle
	always_comb begin
		next_rdata = 32'h0;
		next_err = 1'b0;
		case (paddr)
			cc_pkg::OFF_PWR_CTRL: next_rdata = {27'h0, pwrCtrl};
			cc_pkg::OFF_CLK_ENABLE: next_rdata = {28'h0, clkEnable};
			cc_pkg::OFF_PLL_CTRL: next_rdata = {31'h0, pllCtrl};
			cc_pkg::OFF_CLK_SEL0: next_rdata = {26'h0, clockSelect0};
			cc_pkg::OFF_CLK_SEL1: next_rdata = {24'h0, clockSelect1};
			cc_pkg::OFF_CLK_SEL2: next_rdata = {24'h0, clockSelect2};
			cc_pkg::OFF_DIV_CTRL: next_rdata = {27'h0, clockDividerOutCtrl};
			// Live state: power state, divider run flag, gates, current system source
			cc_pkg::OFF_STATUS: next_rdata = {19'h0, curSel[cc_pkg::MUX_SYS],
				gateOn, divRunning, pstate};
			default: next_err = 1'b1;
		endcase
	end

	// Zero-wait answer: pready rises in the access cycle
	always_ff @(posedge clk) begin
		if (!nrst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end else begin
			pready <= setupPhase;
			pslverr <= setupPhase && next_err;
			if (setupPhase && !pwrite) begin
				prdata <= next_rdata;
			end
		end
	end

	// Register writes land at the access edge; unmapped writes are dropped
	always_ff @(posedge clk) begin
		if (!nrst) begin
			pwrCtrl <= cc_pkg::PWR_CTRL_RESET;
			clkEnable <= cc_pkg::CLK_ENABLE_RESET;
			pllCtrl <= 1'b0;
			clockSelect0 <= cc_pkg::CLK_SEL0_RESET;
			clockSelect1 <= cc_pkg::CLK_SEL12_RESET;
			clockSelect2 <= cc_pkg::CLK_SEL12_RESET;
			clockDividerOutCtrl <= 5'h0;
		end else if (wrEn) begin
			case (paddr)
				cc_pkg::OFF_PWR_CTRL: pwrCtrl <= pwdata[4:0];
				cc_pkg::OFF_CLK_ENABLE: clkEnable <= pwdata[cc_pkg::NUM_PERIPH-1:0];
				cc_pkg::OFF_PLL_CTRL: pllCtrl <= pwdata[0];
				cc_pkg::OFF_CLK_SEL0: clockSelect0 <= pwdata[5:0];
				cc_pkg::OFF_CLK_SEL1: clockSelect1 <= pwdata[7:0];
				cc_pkg::OFF_CLK_SEL2: clockSelect2 <= pwdata[7:0];
				cc_pkg::OFF_DIV_CTRL: clockDividerOutCtrl <= pwdata[4:0];
				default: ;
			endcase
		end
	end

	// ****************************************************************
	// Power-down sequencing
	// ****************************************************************
	// Stability of the source the system clock wants to run from
	always_comb begin
		case (reqSel[cc_pkg::MUX_SYS])
			cc_pkg::SRC_HXT: sysSrcStable = srcStable.hxt;
			cc_pkg::SRC_LXT: sysSrcStable = srcStable.lxt;
			cc_pkg::SRC_PLL: sysSrcStable = srcStable.pll;
			cc_pkg::SRC_LIRC: sysSrcStable = srcStable.lirc;
			default: sysSrcStable = srcStable.hirc;
		endcase
	end

	// Run, down, and wake-until-stable
	always_comb begin
		next_pstate = pstate;
		case (pstate)
			cc_pkg::PS_RUN: begin
				if (pwrCtrl[cc_pkg::POWERDOWN_ENABLE_BIT] && waitForInterruptInstr) begin
					next_pstate = cc_pkg::PS_DOWN;
				end
			end
			cc_pkg::PS_DOWN: begin
				if (wakeIrq) begin
					next_pstate = cc_pkg::PS_WAKE;
				end
			end
			cc_pkg::PS_WAKE: begin
				if (sysSrcStable) begin
					next_pstate = cc_pkg::PS_RUN;
				end
			end
			default: next_pstate = cc_pkg::PS_RUN;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			pstate <= cc_pkg::PS_RUN;
		end else begin
			pstate <= next_pstate;
		end
	end

	// Oscillator enables; high-frequency ones drop while down, low ones stay as programmed
	// The PLL has no enable of its own; it stops only for power-down
	always_ff @(posedge clk) begin
		if (!nrst) begin
			srcEnable <= '0;
			pllRefSelect <= 1'b0;
			powerdownActive <= 1'b0;
		end else begin
			srcEnable.hxt <= pwrCtrl[cc_pkg::PWR_HXT_EN_BIT] && (next_pstate != cc_pkg::PS_DOWN);
			srcEnable.hirc <= pwrCtrl[cc_pkg::PWR_HIRC_EN_BIT] && (next_pstate != cc_pkg::PS_DOWN);
			srcEnable.pll <= (next_pstate != cc_pkg::PS_DOWN);
			srcEnable.lxt <= pwrCtrl[cc_pkg::PWR_LXT_EN_BIT];
			srcEnable.lirc <= pwrCtrl[cc_pkg::PWR_LIRC_EN_BIT];
			pllRefSelect <= pllCtrl;
			powerdownActive <= (next_pstate == cc_pkg::PS_DOWN);
		end
	end

	// ****************************************************************
	// Glitch-free clock multiplexers
	// ****************************************************************
	// Requested source per channel and whether the channel may run
	always_comb begin
		reqSel[cc_pkg::MUX_SYS] = clockSelect0[cc_pkg::SYS_SEL_LSB +: cc_pkg::SEL_W];
		reqSel[cc_pkg::MUX_TICK] = clockSelect0[cc_pkg::TICK_SEL_LSB +: cc_pkg::SEL_W];
		allow[cc_pkg::MUX_SYS] = (pstate == cc_pkg::PS_RUN);
		allow[cc_pkg::MUX_TICK] = (pstate == cc_pkg::PS_RUN);
		for (int p = 0; p < cc_pkg::NUM_PERIPH; p++) begin
			// Two peripherals per select register, one nibble each
			if (p < 2) begin
				reqSel[p + 2] = clockSelect1[p * cc_pkg::PERIPH_SEL_STRIDE +: cc_pkg::SEL_W];
			end else begin
				reqSel[p + 2] = clockSelect2[(p - 2) * cc_pkg::PERIPH_SEL_STRIDE +: cc_pkg::SEL_W];
			end
			allow[p + 2] = clkEnable[p] &&
				((pstate == cc_pkg::PS_RUN) || isLowFreq(curSel[p + 2]));
		end
	end

	// Each channel closes its gate only while its source is low, swaps source
	// with the gate closed, and reopens only while the new source is low;
	// costs up to a source period of dead time per switch, but never a runt pulse.
	genvar m;
	generate
		for (m = 0; m < cc_pkg::NUM_MUX; m++) begin : g_mux
			logic lvl;
			assign lvl = pickSrc(curSel[m], srcLevel);

			always_ff @(posedge clk) begin
				if (!nrst) begin
					curSel[m] <= cc_pkg::SRC_HIRC;
					gateOn[m] <= 1'b0;
					muxOut[m] <= 1'b0;
				end else begin
					if (gateOn[m]) begin
						// Close only on a low phase
						if (!lvl && (!allow[m] || reqSel[m] != curSel[m])) begin
							gateOn[m] <= 1'b0;
							muxOut[m] <= 1'b0;
						end else begin
							muxOut[m] <= lvl;
						end
					end else begin
						muxOut[m] <= 1'b0;
						if (reqSel[m] != curSel[m]) begin
							curSel[m] <= reqSel[m];
						end else if (allow[m] && !lvl) begin
							gateOn[m] <= 1'b1;
						end
					end
				end
			end
		end
	endgenerate

	// ****************************************************************
	// Clock outputs
	// ****************************************************************
	// Tick source: core clock or external tick clock, both already gated
	always_ff @(posedge clk) begin
		if (!nrst) begin
			sysClk <= 1'b0;
			tickClk <= 1'b0;
			periphClk <= '0;
		end else begin
			sysClk <= muxOut[cc_pkg::MUX_SYS];
			tickClk <= tickClockSourceSelect ? (coreClk && muxOut[cc_pkg::MUX_SYS])
				: muxOut[cc_pkg::MUX_TICK];
			periphClk <= muxOut[cc_pkg::NUM_MUX-1:2];
		end
	end

	// ****************************************************************
	// Frequency divider
	// ****************************************************************
	// Divider input is the gated system clock; each of its rising edges advances the chain while divRunning is set
	always_ff @(posedge clk) begin
		if (!nrst) begin
			divInPrev <= 1'b0;
		end else begin
			divInPrev <= muxOut[cc_pkg::MUX_SYS];
		end
	end

	// Counter bit n toggles at Fin/2^(n+1); stopping waits for the chosen bit to be low
	always_ff @(posedge clk) begin
		if (!nrst) begin
			divCount <= '0;
			divRunning <= 1'b0;
		end else begin
			if (clockDividerOutCtrl[cc_pkg::DIV_EN_BIT]) begin
				divRunning <= 1'b1;
			end else if (!divCount[clockDividerOutCtrl[3:0]]) begin
				divRunning <= 1'b0;
			end
			if (divRunning && muxOut[cc_pkg::MUX_SYS] && !divInPrev) begin
				divCount <= divCount + 16'h1;
			end
		end
	end

	// Changing the stage select while running may cut one output phase short;
	// clear the enable and let the output settle low before picking a new stage
	// Sixteen-way stage select onto the clock-out pin
	always_ff @(posedge clk) begin
		if (!nrst) begin
			clockOutPin <= 1'b0;
		end else begin
			clockOutPin <= divRunning && divCount[clockDividerOutCtrl[3:0]];
		end
	end

endmodule : cc_clock_ctrl

`default_nettype wire

/* cc_clock_ctrl_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Clock controller port checker
// ****************************************
module cc_clock_ctrl_assertions (
	input wire logic clk,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic waitForInterruptInstr,
	input wire logic wakeIrq,
	input wire cc_pkg::cc_src_t srcEnable,
	input wire logic sysClk,
	input wire logic tickClk,
	input wire logic clockOutPin,
	input wire logic powerdownActive
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	// Setup phase of a bus transfer
	sequence apb_setup;
		psel && !penable;
	endsequence
	// Cycles spent in power-down, saturating; a slow source may hold its
	// gate open for a whole high phase before it is allowed to close
	logic [5:0] pdCycles;
	always_ff @(posedge clk) begin
		if (!nrst || !powerdownActive) begin
			pdCycles <= 6'h00;
		end else if (pdCycles != 6'h3f) begin
			pdCycles <= pdCycles + 6'h01;
		end
	end
	// Long enough in power-down for the system and tick gates to have closed
	sequence pd_settled;
		powerdownActive && (pdCycles >= 6'h28);
	endsequence
	chk_ready_after_setup: assert property (apb_setup |=> pready)
		else $error("no ready after setup");
	chk_ready_one_cycle: assert property (pready |=> !pready)
		else $error("ready held too long");
	chk_err_with_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
	chk_enter_on_sleep: assert property ($rose(powerdownActive) |-> $past(waitForInterruptInstr))
		else $error("power-down without sleep");
	chk_stay_down: assert property (powerdownActive && !wakeIrq |=> powerdownActive)
		else $error("left power-down without wake");
	chk_leave_on_wake: assert property (powerdownActive && wakeIrq |=> !powerdownActive)
		else $error("wake ignored");
	chk_hf_stopped: assert property (powerdownActive |-> !srcEnable.hxt && !srcEnable.hirc)
		else $error("fast source kept in power-down");
	chk_clocks_gated: assert property (pd_settled |-> !sysClk && !tickClk)
		else $error("system clock runs in power-down");
	chk_divout_no_runt: assert property ($rose(clockOutPin) |=> clockOutPin)
		else $error("runt pulse on clock out");
endmodule : cc_clock_ctrl_assertions
`default_nettype wire

/* cc_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Core and oscillator model
// ****************************************
module cc_core_model (
	input wire logic clk,
	input wire logic nrst,
	input wire logic sleepCmd,
	input wire logic wakeCmd,
	input wire cc_pkg::cc_src_t srcEnable,
	output logic waitForInterruptInstr,
	output logic wakeIrq,
	output logic coreClk,
	output cc_pkg::cc_src_t srcLevel,
	output cc_pkg::cc_src_t srcStable
);
	logic [4:0] phase;
	// Sleep and wake arrive from the core as registered one-cycle pulses
	always_ff @(posedge clk) begin
		if (!nrst) begin
			phase <= 5'h00;
			waitForInterruptInstr <= 1'b0;
			wakeIrq <= 1'b0;
			srcStable <= 5'h00;
		end else begin
			phase <= phase + 5'h01;
			waitForInterruptInstr <= sleepCmd;
			wakeIrq <= wakeCmd;
			srcStable <= srcEnable; // Settles one cycle after enable
		end
	end
	// Stopped oscillators sit low; each source runs at its own rate
	assign srcLevel = {phase[2], phase[4], phase[1], phase[3], phase[0]} & srcEnable;
	assign coreClk = phase[0];
endmodule : cc_core_model
`default_nettype wire

/* cc_pkg.sv */
// ****************************************************************
// Clock controller shared definitions
// ****************************************************************
package cc_pkg;

	// Register byte offsets
	localparam logic [7:0] OFF_PWR_CTRL = 8'h00;
	localparam logic [7:0] OFF_CLK_ENABLE = 8'h04;
	localparam logic [7:0] OFF_PLL_CTRL = 8'h08;
	localparam logic [7:0] OFF_CLK_SEL0 = 8'h0c;
	localparam logic [7:0] OFF_CLK_SEL1 = 8'h10;
	localparam logic [7:0] OFF_CLK_SEL2 = 8'h14;
	localparam logic [7:0] OFF_DIV_CTRL = 8'h18;
	localparam logic [7:0] OFF_STATUS = 8'h1c;

	// Power control fields
	localparam int POWERDOWN_ENABLE_BIT = 0;
	localparam int PWR_HXT_EN_BIT = 1;
	localparam int PWR_LXT_EN_BIT = 2;
	localparam int PWR_HIRC_EN_BIT = 3;
	localparam int PWR_LIRC_EN_BIT = 4;
	localparam logic [4:0] PWR_CTRL_RESET = 5'h18;

	// Clock select fields
	localparam int SEL_W = 3;
	localparam int SYS_SEL_LSB = 0;
	localparam int TICK_SEL_LSB = 3;
	localparam int PERIPH_SEL_STRIDE = 4;
	localparam logic [5:0] CLK_SEL0_RESET = 6'h3f;
	localparam logic [7:0] CLK_SEL12_RESET = 8'h77;

	// Divider fields
	localparam int DIV_SEL_LSB = 0;
	localparam int DIV_EN_BIT = 4;
	localparam int DIV_STAGES = 16;

	// Peripheral clock channels
	localparam int NUM_PERIPH = 4;
	localparam int NUM_MUX = NUM_PERIPH + 2;
	localparam int MUX_SYS = 0;
	localparam int MUX_TICK = 1;
	localparam logic [NUM_PERIPH-1:0] CLK_ENABLE_RESET = 4'h0;

	// Source encodings of a select field
	localparam logic [2:0] SRC_HXT = 3'h0;
	localparam logic [2:0] SRC_LXT = 3'h1;
	localparam logic [2:0] SRC_PLL = 3'h2;
	localparam logic [2:0] SRC_LIRC = 3'h3;
	localparam logic [2:0] SRC_HIRC = 3'h7;

	// Power sequencing states
	typedef enum logic [2:0] {
		PS_RUN = 3'b001,
		PS_DOWN = 3'b010,
		PS_WAKE = 3'b100
	} cc_pstate_t;

	// One bit per clock source
	typedef struct packed {
		logic hirc;
		logic lirc;
		logic pll;
		logic lxt;
		logic hxt;
	} cc_src_t;

endpackage : cc_pkg

/* cc_tb.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Clock controller testbench
// ****************************************
module tb;
	logic clk, nrst, psel, penable, pwrite, sleepCmd, wakeCmd, tickSel;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic pready, pslverr, err, pllRefSelect, sysClk, tickClk, clockOutPin;
	logic powerdownActive, sleepInstr, wake, coreClk;
	logic [3:0] periphClk;
	cc_pkg::cc_src_t srcLevel, srcStable, srcEnable;
	int n_errors, check_count, cycles, cnt;
	logic [7:0] addrTab [6] = '{8'h00, 8'h04, 8'h0c, 8'h10, 8'h14, 8'h18};
	logic [31:0] rstTab [6] = '{32'h18, 32'h0, 32'h3f, 32'h77, 32'h77, 32'h0};

	cc_clock_ctrl cc_clock_ctrl_inst (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .srcLevel(srcLevel), .srcStable(srcStable),
		.waitForInterruptInstr(sleepInstr), .wakeIrq(wake), .coreClk(coreClk),
		.tickClockSourceSelect(tickSel), .srcEnable(srcEnable), .pllRefSelect(pllRefSelect),
		.sysClk(sysClk), .tickClk(tickClk), .periphClk(periphClk),
		.clockOutPin(clockOutPin), .powerdownActive(powerdownActive));
	cc_core_model cc_core_model_inst (.clk(clk), .nrst(nrst), .sleepCmd(sleepCmd),
		.wakeCmd(wakeCmd), .srcEnable(srcEnable), .waitForInterruptInstr(sleepInstr),
		.wakeIrq(wake),
		.coreClk(coreClk), .srcLevel(srcLevel), .srcStable(srcStable));

	// Free-running 100 MHz clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Cut a hang short well past the expected run length
	initial begin
		forever begin
			@(posedge clk);
			cycles++;
			if (cycles == 20000) begin
				n_errors++;
				complete_run();
			end
		end
	end

	task complete_run();
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : complete_run

	task check(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	// Request is held until ready is sampled high, then released
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task pulse(input logic w);
		@(posedge clk);
		if (w)
			wakeCmd <= 1'b1;
		else
			sleepCmd <= 1'b1;
		@(posedge clk);
		wakeCmd <= 1'b0;
		sleepCmd <= 1'b0;
		repeat (4) @(posedge clk);
	endtask : pulse

	function automatic logic pick(input int k);
		return (k == 0) ? sysClk : (k == 1) ? periphClk[0] : (k == 3) ? tickClk : clockOutPin;
	endfunction : pick

	task countRise(input int k, input int len, output int n);
		logic prev;
		n = 0;
		prev = pick(k);
		repeat (len) begin
			@(posedge clk);
			if (pick(k) === 1'b1 && prev === 1'b0) n++;
			prev = pick(k);
		end
	endtask : countRise

	// System clock rises within one full clock-out period
	task divPeriod(output int n);
		logic prev;
		int seen;
		n = 0;
		seen = 0;
		prev = sysClk;
		while (seen < 4) begin
			@(posedge clk);
			if (sysClk === 1'b1 && prev === 1'b0) n++;
			prev = sysClk;
			if (clockOutPin === seen[0]) begin
				seen++;
				if (seen == 2) n = 0;
			end
		end
	endtask : divPeriod

	// Main sequence
	initial begin
		{nrst, psel, penable, pwrite, sleepCmd, wakeCmd, tickSel} = 7'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			apb(1'b0, addrTab[i], 32'h0);
			check("reset value", rstTab[i], rd);
		end
		apb(1'b1, 8'h20, 32'h5);
		check("unmapped error", 32'h1, 32'(err));
		apb(1'b0, 8'h20, 32'h0);
		check("unmapped data", 32'h0, rd);
		apb(1'b1, cc_pkg::OFF_CLK_SEL0, 32'hffffffdf);
		apb(1'b0, cc_pkg::OFF_CLK_SEL0, 32'h0);
		check("select 0", 32'h1f, rd);
		for (int n = 0; n < 4; n += 3) begin
			apb(1'b1, cc_pkg::OFF_DIV_CTRL, 32'h10 | n);
			divPeriod(cnt);
			check("divider period", 32'(1 << (n + 1)), 32'(cnt));
		end
		apb(1'b1, cc_pkg::OFF_DIV_CTRL, 32'h0);
		countRise(2, 200, cnt);
		check("divider stopped", 32'h0, 32'(cnt));
		check("divider low", 32'h0, 32'(clockOutPin));
		countRise(3, 64, cnt);
		check("tick external", 32'h2, 32'(cnt));
		tickSel <= 1'b1;
		countRise(3, 64, cnt);
		check("tick core clock", 32'h1, 32'(cnt > 2));
		tickSel <= 1'b0;
		apb(1'b1, cc_pkg::OFF_PLL_CTRL, 32'h1);
		apb(1'b0, cc_pkg::OFF_PLL_CTRL, 32'h0);
		check("pll ref readback", 32'h1, rd);
		check("pll ref select", 32'h1, 32'(pllRefSelect));
		pulse(1'b0);
		check("down without enable", 32'h0, 32'(powerdownActive));
		apb(1'b1, cc_pkg::OFF_CLK_SEL1, 32'h73);
		apb(1'b1, cc_pkg::OFF_CLK_ENABLE, 32'h1);
		apb(1'b1, cc_pkg::OFF_PWR_CTRL, 32'h19);
		pulse(1'b0);
		check("down entered", 32'h1, 32'(powerdownActive));
		check("fast enables", 32'h0, 32'({srcEnable.hirc, srcEnable.hxt}));
		check("slow enable", 32'h1, 32'(srcEnable.lirc));
		countRise(1, 96, cnt);
		check("slow peripheral runs", 32'h1, 32'(cnt > 0));
		countRise(0, 96, cnt);
		check("system clock stopped", 32'h0, 32'(cnt));
		check("still down", 32'h1, 32'(powerdownActive));
		pulse(1'b1);
		check("woken", 32'h0, 32'(powerdownActive));
		check("oscillator restarted", 32'h1, 32'(srcEnable.hirc));
		countRise(0, 64, cnt);
		check("system clock resumed", 32'h1, 32'(cnt > 0));
		complete_run();
	end
endmodule : tb

bind cc_clock_ctrl cc_clock_ctrl_assertions cc_clock_ctrl_assertions_inst (.clk(clk),
	.nrst(nrst), .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
	.waitForInterruptInstr(waitForInterruptInstr), .wakeIrq(wakeIrq), .srcEnable(srcEnable),
	.sysClk(sysClk), .tickClk(tickClk), .clockOutPin(clockOutPin),
	.powerdownActive(powerdownActive));
`default_nettype wire
